// ==== core/adri_defs.svh ====
`ifndef ADRI_DEFS_SVH
`define ADRI_DEFS_SVH

// Register bus base and byte offsets
`define ADRI_BASE_ADDR 16'hFFE0
`define ADRI_OFS_RES_A_HI 4'h0
`define ADRI_OFS_RES_A_LO 4'h1
`define ADRI_OFS_RES_B_HI 4'h2
`define ADRI_OFS_RES_B_LO 4'h3
`define ADRI_OFS_RES_C_HI 4'h4
`define ADRI_OFS_RES_C_LO 4'h5
`define ADRI_OFS_RES_D_HI 4'h6
`define ADRI_OFS_RES_D_LO 4'h7
`define ADRI_OFS_CSR 4'h8
`define ADRI_OFS_TRIG 4'h9

// Control/status field positions
`define ADRI_CSR_END_FLAG 7
`define ADRI_CSR_IRQ_EN 6
`define ADRI_CSR_START 5
`define ADRI_CSR_SCAN 4
`define ADRI_CSR_SPEED 3
`define ADRI_CSR_GROUP 2

// Trigger control field positions
`define ADRI_TRIG_ENABLE 7

// Reset values
`define ADRI_RES_RESET 10'h000
`define ADRI_CSR_RESET 8'h00
`define ADRI_TRIG_RESET 8'h7E
`define ADRI_TRIG_ONES 6'h3F

// Timing, in states; one state is one core clock
`define ADRI_STATE_CYCLES 1
`define ADRI_FIRST_SLOW_STATES 266
`define ADRI_FIRST_FAST_STATES 134
`define ADRI_NEXT_SLOW_STATES 256
`define ADRI_NEXT_FAST_STATES 128
`define ADRI_FIRST_SLOW_CYCLES (`ADRI_FIRST_SLOW_STATES * `ADRI_STATE_CYCLES)
`define ADRI_FIRST_FAST_CYCLES (`ADRI_FIRST_FAST_STATES * `ADRI_STATE_CYCLES)
`define ADRI_NEXT_SLOW_CYCLES (`ADRI_NEXT_SLOW_STATES * `ADRI_STATE_CYCLES)
`define ADRI_NEXT_FAST_CYCLES (`ADRI_NEXT_FAST_STATES * `ADRI_STATE_CYCLES)

`endif

// ==== core/adri_pkg.sv ====
package adri_pkg;

  // Conversion engine states
  typedef enum logic [0:0] {
    ADRI_IDLE = 1'b0,
    ADRI_CONVERT = 1'b1
  } adri_state_t;

  typedef logic [9:0] adri_result_t;
  typedef logic [8:0] adri_count_t;

endpackage : adri_pkg

// ==== core/adri_trig_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
module adri_trig_edge (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Trigger pin and enable
  input wire logic ext_trigger_input_i,
  input wire logic ext_trigger_enable_i,
  // Start request
  output logic trig_start_o
);

  logic trig_prev;

  // Previous level; resets high, so a pin held low at reset release counts as a falling edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      trig_prev <= 1'b1;
    end else begin
      trig_prev <= ext_trigger_input_i;
    end
  end

  // Falling edge only counts while enabled
  assign trig_start_o = ext_trigger_enable_i & trig_prev & ~ext_trigger_input_i;

endmodule : adri_trig_edge
`default_nettype wire

// ==== core/adri_conv_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adri_defs.svh"
module adri_conv_core
  import adri_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control from the status register
  input wire logic start_i,
  input wire logic scan_i,
  input wire logic speed_i,
  input wire logic [2:0] chan_sel_i,
  // Analog core
  input wire logic [9:0] conv_value_i,
  output logic [2:0] conv_channel_o,
  output logic conv_busy_o,
  // Completion
  output logic result_valid_o,
  output logic [1:0] result_index_o,
  output logic [9:0] result_data_o,
  output logic single_end_o,
  output logic scan_end_o
);

  adri_state_t state;
  adri_count_t count;
  logic first;
  logic count_end;
  logic last_chan;

  // Length of the current conversion, first one longer
  function automatic adri_count_t conv_len(input logic is_first, input logic fast);
    if (is_first) begin
      conv_len = fast ? adri_count_t'(`ADRI_FIRST_FAST_CYCLES) : adri_count_t'(`ADRI_FIRST_SLOW_CYCLES);
    end else begin
      conv_len = fast ? adri_count_t'(`ADRI_NEXT_FAST_CYCLES) : adri_count_t'(`ADRI_NEXT_SLOW_CYCLES);
    end
  endfunction : conv_len

  assign count_end = (state == ADRI_CONVERT) && (count == conv_len(first, speed_i) - adri_count_t'(1));
  assign last_chan = scan_i ? (conv_channel_o[1:0] == chan_sel_i[1:0]) : 1'b1;
  assign conv_busy_o = (state == ADRI_CONVERT);

  // Sequencer; a dropped start aborts with no result
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= ADRI_IDLE;
      count <= '0;
      first <= 1'b1;
      conv_channel_o <= 3'h0;
    end else begin
      case (state)
        ADRI_IDLE: begin
          count <= '0;
          first <= 1'b1;
          // Start is still high in the end cycle; a restart then would be spurious
          if (start_i && !single_end_o) begin
            state <= ADRI_CONVERT;
            conv_channel_o <= scan_i ? {chan_sel_i[2], 2'b00} : chan_sel_i;
          end
        end
        ADRI_CONVERT: begin
          if (!start_i) begin
            state <= ADRI_IDLE;
          end else if (count_end) begin
            count <= '0;
            first <= 1'b0;
            if (!scan_i) begin
              state <= ADRI_IDLE;
            end else if (last_chan) begin
              conv_channel_o <= {chan_sel_i[2], 2'b00};
            end else begin
              conv_channel_o <= conv_channel_o + 3'h1;
            end
          end else begin
            count <= count + adri_count_t'(1);
          end
        end
        default: begin
          state <= ADRI_IDLE;
        end
      endcase
    end
  end

  // Completion pulses, suppressed when start drops the same cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      result_valid_o <= 1'b0;
      result_index_o <= 2'h0;
      result_data_o <= `ADRI_RES_RESET;
      single_end_o <= 1'b0;
      scan_end_o <= 1'b0;
    end else begin
      result_valid_o <= count_end & start_i;
      single_end_o <= count_end & start_i & ~scan_i;
      scan_end_o <= count_end & start_i & scan_i & last_chan;
      if (count_end && start_i) begin
        result_index_o <= conv_channel_o[1:0];
        result_data_o <= conv_value_i;
      end
    end
  end

endmodule : adri_conv_core
`default_nettype wire

// ==== core/adri_top.sv ====
// Behaviour
// - Result bits 9..2 go to the upper byte, bits 1..0 to lower bits 7..6.
// - Lower-byte bits 5..0 of every result register read as zero.
// - Inputs 0/4 fill A, 1/5 fill B, 2/6 fill C, 3/7 fill D.
// - Results clear to zero on reset and in standby.
// - Control/status clears to zero on reset and in standby.
// - End flag sets after a single conversion or a full scan pass.
// - End flag clears only by writing zero after reading it as one.
// - Interrupt requested when end flag and enable are both one.
// - Start bit set by software or trigger begins conversion, stays one meanwhile.
// - Single mode clears the start bit when its conversion finishes.
// - Scan mode cycles channels until start is cleared, reset or standby.
// - Bit 4 picks single or scan; software stops before changing it.
// - Speed bit: zero gives 266 states, one gives 134 states at most.
// - Channel bits pick one input, or group and count in scan mode.
// - Trigger control loads 0x7E on reset and in standby.
// - Trigger enable one: falling trigger edge starts conversion; zero ignores it.
// - Trigger bits 6..1 read one; software never sets bit 0.
// - Upper-byte read returns it and copies lower byte to holding latch.
// - Lower-byte read returns the holding latch.
// - Results A..D sit lowest, then control/status, then trigger control.
// - Scan starts at group's first channel, steps on at once.
// - Scan conversions after the first take 256 or 128 states.
`timescale 1ns/1ps
`default_nettype none
`include "adri_defs.svh"
module adri_top
  import adri_pkg::*;
(
  // Clock, reset and standby
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic standby_i,
  // CPU byte bus
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  // Analog core
  input wire logic [9:0] conv_value_i,
  output logic [2:0] conv_channel_o,
  output logic conv_busy_o,
  // External trigger
  input wire logic ext_trigger_input_i,
  // Interrupt
  output logic conv_end_interrupt_o
);

  // Registers
  adri_result_t result_a;
  adri_result_t result_b;
  adri_result_t result_c;
  adri_result_t result_d;
  logic conv_end_flag;
  logic conv_end_irq_enable;
  logic conv_start_bit;
  logic scan_mode;
  logic conv_speed_select;
  logic [2:0] chan_sel;
  logic ext_trigger_enable;
  logic trig_reserved0;
  logic [7:0] hold_latch;
  logic flag_read_seen;

  // Decoded access
  logic clear_all;
  logic hit;
  logic [3:0] offs;
  logic rd_csr;
  logic wr_csr;
  logic wr_trig;
  logic [7:0] csr_value;
  logic [7:0] trig_value;
  logic [7:0] next_rdata;
  logic trig_start;
  logic result_valid;
  logic [1:0] result_index;
  adri_result_t result_data;
  adri_result_t sel_result;
  logic single_end;
  logic scan_end;

  // Standby acts as a held reset of all state
  assign clear_all = reset_i | standby_i;

  // Address decode over the ten-byte window
  assign hit = (bus_addr_i[15:4] == 12'(`ADRI_BASE_ADDR >> 4)) && (bus_addr_i[3:0] <= `ADRI_OFS_TRIG);
  assign offs = bus_addr_i[3:0];
  assign rd_csr = bus_rd_i & hit & (offs == `ADRI_OFS_CSR);
  assign wr_csr = bus_wr_i & hit & (offs == `ADRI_OFS_CSR);
  assign wr_trig = bus_wr_i & hit & (offs == `ADRI_OFS_TRIG);

  assign csr_value = {conv_end_flag, conv_end_irq_enable, conv_start_bit, scan_mode,
                      conv_speed_select, chan_sel};
  assign trig_value = {ext_trigger_enable, `ADRI_TRIG_ONES, trig_reserved0};

  // Selects the result register behind a byte pair
  function automatic adri_result_t pick_result(input logic [3:0] o, input adri_result_t a,
                                               input adri_result_t b, input adri_result_t c,
                                               input adri_result_t d);
    if (o[2:1] == 2'b00) begin
      pick_result = a;
    end else if (o[2:1] == 2'b01) begin
      pick_result = b;
    end else if (o[2:1] == 2'b10) begin
      pick_result = c;
    end else begin
      pick_result = d;
    end
  endfunction : pick_result

  // Result register addressed by the current byte pair
  assign sel_result = pick_result(offs, result_a, result_b, result_c, result_d);

  // Falling-edge trigger detect
  adri_trig_edge i_adri_trig_edge (
    .core_clk_i(core_clk_i),
    .reset_i(clear_all),
    .ext_trigger_input_i(ext_trigger_input_i),
    .ext_trigger_enable_i(ext_trigger_enable),
    .trig_start_o(trig_start)
  );

  // Conversion sequencer and timing
  adri_conv_core i_adri_conv_core (
    .core_clk_i(core_clk_i),
    .reset_i(clear_all),
    .start_i(conv_start_bit),
    .scan_i(scan_mode),
    .speed_i(conv_speed_select),
    .chan_sel_i(chan_sel),
    .conv_value_i(conv_value_i),
    .conv_channel_o(conv_channel_o),
    .conv_busy_o(conv_busy_o),
    .result_valid_o(result_valid),
    .result_index_o(result_index),
    .result_data_o(result_data),
    .single_end_o(single_end),
    .scan_end_o(scan_end)
  );

  // Result registers, written by channel pairing
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      result_a <= `ADRI_RES_RESET;
      result_b <= `ADRI_RES_RESET;
      result_c <= `ADRI_RES_RESET;
      result_d <= `ADRI_RES_RESET;
    end else if (result_valid) begin
      case (result_index)
        2'h0: begin
          result_a <= result_data;
        end
        2'h1: begin
          result_b <= result_data;
        end
        2'h2: begin
          result_c <= result_data;
        end
        default: begin
          result_d <= result_data;
        end
      endcase
    end
  end

  // Control fields; software owns them, start also set by trigger
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      conv_end_irq_enable <= 1'(`ADRI_CSR_RESET >> `ADRI_CSR_IRQ_EN);
      conv_start_bit <= 1'b0;
      scan_mode <= 1'b0;
      conv_speed_select <= 1'b0;
      chan_sel <= 3'h0;
    end else begin
      if (wr_csr) begin
        conv_end_irq_enable <= bus_wdata_i[`ADRI_CSR_IRQ_EN];
        scan_mode <= bus_wdata_i[`ADRI_CSR_SCAN];
        conv_speed_select <= bus_wdata_i[`ADRI_CSR_SPEED];
        chan_sel <= bus_wdata_i[`ADRI_CSR_GROUP:0];
      end
      // A new start request outranks the single-mode auto clear
      if (trig_start || (wr_csr && bus_wdata_i[`ADRI_CSR_START])) begin
        conv_start_bit <= 1'b1;
      end else if (wr_csr) begin
        conv_start_bit <= 1'b0;
      end else if (single_end) begin
        conv_start_bit <= 1'b0;
      end
    end
  end

  // End flag: completion wins over a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      conv_end_flag <= 1'b0;
      flag_read_seen <= 1'b0;
    end else begin
      if (single_end || scan_end) begin
        conv_end_flag <= 1'b1;
      end else if (wr_csr && !bus_wdata_i[`ADRI_CSR_END_FLAG] && flag_read_seen) begin
        conv_end_flag <= 1'b0;
      end
      // Arm the clear only on a read that saw the flag set
      if (rd_csr && conv_end_flag) begin
        flag_read_seen <= 1'b1;
      end else if (wr_csr || !conv_end_flag) begin
        flag_read_seen <= 1'b0;
      end
    end
  end

  // Trigger control; reserved bit 0 kept as written
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      ext_trigger_enable <= 1'(`ADRI_TRIG_RESET >> `ADRI_TRIG_ENABLE);
      trig_reserved0 <= 1'(`ADRI_TRIG_RESET & 8'h01);
    end else if (wr_trig) begin
      ext_trigger_enable <= bus_wdata_i[`ADRI_TRIG_ENABLE];
      trig_reserved0 <= bus_wdata_i[0];
    end
  end

  // Holding latch loaded by any upper-byte read
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      hold_latch <= 8'h00;
    end else if (bus_rd_i && hit && !offs[3] && !offs[0]) begin
      hold_latch <= {sel_result[1:0], 6'h00};
    end
  end

  // Read data mux; unmapped bytes return zero
  always_comb begin
    next_rdata = 8'h00;
    if (!hit) begin
      next_rdata = 8'h00;
    end else if (offs == `ADRI_OFS_CSR) begin
      next_rdata = csr_value;
    end else if (offs == `ADRI_OFS_TRIG) begin
      next_rdata = trig_value;
    end else if (offs[0]) begin
      next_rdata = hold_latch;
    end else begin
      next_rdata = sel_result[9:2];
    end
  end

  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_rd_i) begin
      bus_rdata_o <= next_rdata;
    end
  end

  // Level request, drops with either source
  assign conv_end_interrupt_o = conv_end_flag & conv_end_irq_enable;

endmodule : adri_top
`default_nettype wire

// ==== tb/adri_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module adri_top_sva (
  // Clock, reset and standby
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic standby_i,
  // CPU byte bus
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  // Converter, trigger and interrupt
  input wire logic [9:0] conv_value_i,
  input wire logic [2:0] conv_channel_o,
  input wire logic conv_busy_o,
  input wire logic ext_trigger_input_i,
  input wire logic conv_end_interrupt_o
);
  logic clr;
  logic [11:0] busy_len;
  logic trg_en;
  logic ie_sh;
  assign clr = reset_i || standby_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (clr);
  // Busy run length, restarted whenever the engine idles
  always_ff @(posedge core_clk_i) begin
    if (clr || !conv_busy_o)
      busy_len <= 12'h000;
    else
      busy_len <= busy_len + 12'h001;
  end
  // Shadows of the enable bits, since no register is visible here
  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      trg_en <= 1'b0;
      ie_sh <= 1'b0;
    end else if (bus_wr_i && bus_addr_i == 16'hFFE9) begin
      trg_en <= bus_wdata_i[7];
    end else if (bus_wr_i && bus_addr_i == 16'hFFE8) begin
      ie_sh <= bus_wdata_i[6];
    end
  end
  standby_clear_a: assert property (
    disable iff (reset_i) standby_i |=> !conv_busy_o && !conv_end_interrupt_o && bus_rdata_o == 8'h00)
    else $error("standby left state behind");
  unmapped_zero_a: assert property (
    bus_rd_i && (bus_addr_i < 16'hFFE0 || bus_addr_i > 16'hFFE9) |=> bus_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  trig_ones_a: assert property (
    bus_rd_i && bus_addr_i == 16'hFFE9 |=> bus_rdata_o[6:1] == 6'h3F)
    else $error("trigger control fixed bits wrong");
  low_zero_a: assert property (
    bus_rd_i && bus_addr_i[15:3] == 13'h1FFC && bus_addr_i[0] |=> bus_rdata_o[5:0] == 6'h00)
    else $error("result low byte padding not zero");
  irq_fall_a: assert property (
    $fell(conv_end_interrupt_o) |-> $past(bus_wr_i) && $past(bus_addr_i) == 16'hFFE8)
    else $error("interrupt dropped without a status write");
  conv_len_a: assert property (
    $fell(conv_busy_o) && !$past(bus_wr_i) && !$past(bus_wr_i, 2) |-> busy_len == 12'h10A || busy_len == 12'h086)
    else $error("conversion length wrong");
  trig_off_a: assert property (
    $fell(ext_trigger_input_i) && !trg_en && !conv_busy_o && !bus_wr_i && !$past(bus_wr_i) && !$past(bus_wr_i, 2)
    |=> !conv_busy_o [*2])
    else $error("disabled trigger started a conversion");
  trig_on_a: assert property (
    $fell(ext_trigger_input_i) && trg_en && !conv_busy_o |-> ##[1:8] conv_busy_o)
    else $error("enabled trigger did not start");
  irq_enable_a: assert property (
    conv_end_interrupt_o |-> ie_sh)
    else $error("interrupt while disabled");
  irq_rise_a: assert property (
    $rose(conv_end_interrupt_o) |-> $past(conv_busy_o, 2) || $past(bus_wr_i))
    else $error("interrupt rose without conversion end");
endmodule : adri_top_sva
bind adri_top adri_top_sva i_adri_top_sva (.core_clk_i, .reset_i, .standby_i, .bus_addr_i, .bus_rd_i, .bus_wr_i,
  .bus_wdata_i, .bus_rdata_o, .conv_value_i, .conv_channel_o, .conv_busy_o, .ext_trigger_input_i,
  .conv_end_interrupt_o);
`default_nettype wire

// ==== tb/adri_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adri_cpu_model (
  // Clock
  input wire logic core_clk_i,
  // Byte bus towards the converter
  output logic [15:0] bus_addr_o,
  output logic bus_rd_o,
  output logic bus_wr_o,
  output logic [7:0] bus_wdata_o
);
  // Idle bus; parked lines show the inverse so stale values never look valid
  initial begin
    bus_addr_o = 16'h0000;
    bus_rd_o = 1'b0;
    bus_wr_o = 1'b0;
    bus_wdata_o = 8'h00;
  end
  // One byte read, strobe held across exactly one rising edge
  task automatic rd(input logic [15:0] a);
    @(negedge core_clk_i);
    bus_addr_o = a;
    bus_rd_o = 1'b1;
    @(negedge core_clk_i);
    bus_rd_o = 1'b0;
    bus_addr_o = ~a;
  endtask : rd
  // One byte write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    bus_addr_o = a;
    bus_wdata_o = d;
    bus_wr_o = 1'b1;
    @(negedge core_clk_i);
    bus_wr_o = 1'b0;
    bus_addr_o = ~a;
    bus_wdata_o = ~d;
  endtask : wr
endmodule : adri_cpu_model
`default_nettype wire

// ==== tb/adri_register_interface_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module adri_register_interface_test;
  import adri_pkg::*;
  logic clk, reset, standby, rd, wr, busy, trig, irq, rd_seen;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [9:0] value;
  logic [2:0] chan;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  adri_result_t res_m[4];
  int bad_count, comparisons;
  adri_top i_adri_top (.core_clk_i(clk), .reset_i(reset), .standby_i(standby), .bus_addr_i(addr),
    .bus_rd_i(rd), .bus_wr_i(wr), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .conv_value_i(value),
    .conv_channel_o(chan), .conv_busy_o(busy), .ext_trigger_input_i(trig), .conv_end_interrupt_o(irq));
  adri_cpu_model i_adri_cpu_model (.core_clk_i(clk), .bus_addr_o(addr), .bus_rd_o(rd), .bus_wr_o(wr),
    .bus_wdata_o(wdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  task automatic check_data(input logic [7:0] e, input logic [7:0] got);
    comparisons++;
    if (got !== e) begin
      bad_count++;
      $display("MISMATCH read data expected %h seen %h", e, got);
    end
  endtask : check_data
  task automatic check_bit(input string what, input logic e, input logic got);
    comparisons++;
    if (got !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, e, got);
    end
  endtask : check_bit
  // Read answers land one edge after the strobe; compare them in order
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) check_data(exp_q.pop_front(), rdata);
  end
  task automatic rx(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_adri_cpu_model.rd(a);
  endtask : rx
  // Upper byte first, so the low byte comes from the holding latch
  task automatic rres(input int r);
    rx(16'hFFE0 + 16'(2 * r), res_m[r][9:2]);
    rx(16'hFFE1 + 16'(2 * r), {res_m[r][1:0], 6'h00});
  endtask : rres
  // Bounded wait for the interrupt, or for the engine to idle
  task automatic wait_for(input logic for_irq);
    int n;
    n = 0;
    repeat (8) @(negedge clk);
    while ((for_irq ? irq !== 1'b1 : busy !== 1'b0) && n < 1500) begin
      @(negedge clk);
      n++;
    end
    // Flag and result land one edge after busy drops
    @(negedge clk);
    check_bit("wait", 1'b1, for_irq ? irq : ~busy);
  endtask : wait_for
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // Watchdog, well beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    logic [7:0] csr;
    reset = 1'b1;
    standby = 1'b0;
    trig = 1'b1;
    value = 10'h000;
    seed = 32'h0000001E;
    bad_count = 0;
    comparisons = 0;
    res_m = '{default: 10'h000};
    repeat (20) @(negedge clk);
    reset = 1'b0;
    // Whole map after reset, plus one address either side
    for (int a = 0; a < 12; a++) rx(16'hFFDF + 16'(a), a == 10 ? 8'h7E : 8'h00);
    i_adri_cpu_model.wr(16'hFFE9, 8'h00);
    rx(16'hFFE9, 8'h7E);
    // Single conversions on every input, both speeds, last one masked
    for (int i = 0; i < 8; i++) begin
      value = 10'(xorshift());
      csr = {1'b0, i != 7, 1'b1, 1'b0, 1'(i), 3'(i)};
      i_adri_cpu_model.wr(16'hFFE8, csr);
      wait_for(1'b0);
      res_m[i % 4] = value;
      check_bit("irq", i != 7, irq);
      i_adri_cpu_model.wr(16'hFFE8, (csr & 8'h5F) | 8'h80);
      rx(16'hFFE8, csr ^ 8'hA0);
      i_adri_cpu_model.wr(16'hFFE8, 8'h40);
      check_bit("irq", 1'b0, irq);
      rres(i % 4);
    end
    rx(16'hFFE6, res_m[3][9:2]);
    rx(16'hFFE1, {res_m[3][1:0], 6'h00});
    // Scan of inputs 4..6, fast, then abort mid-pass
    value = 10'(xorshift());
    i_adri_cpu_model.wr(16'hFFE8, 8'h7E);
    wait_for(1'b1);
    repeat (3) @(negedge clk);
    check_bit("busy", 1'b1, busy);
    check_bit("channel", 1'b1, chan === 3'h4);
    for (int r = 0; r < 3; r++) res_m[r] = value;
    i_adri_cpu_model.wr(16'hFFE8, 8'h00);
    value = ~value;
    repeat (300) @(negedge clk);
    check_bit("busy", 1'b0, busy);
    rx(16'hFFE8, 8'h80);
    for (int r = 0; r < 4; r++) rres(r);
    i_adri_cpu_model.wr(16'hFFE8, 8'h01);
    // Trigger ignored while disabled, honoured once enabled
    value = 10'(xorshift());
    trig = 1'b0;
    repeat (8) @(negedge clk);
    trig = 1'b1;
    check_bit("busy", 1'b0, busy);
    i_adri_cpu_model.wr(16'hFFE9, 8'h80);
    trig = 1'b0;
    wait_for(1'b0);
    trig = 1'b1;
    res_m[1] = value;
    rres(1);
    rx(16'hFFE8, 8'h81);
    rx(16'hFFE9, 8'hFE);
    // Standby in mid-scan clears everything
    i_adri_cpu_model.wr(16'hFFE8, 8'h73);
    repeat (50) @(negedge clk);
    standby = 1'b1;
    repeat (3) @(negedge clk);
    standby = 1'b0;
    check_bit("busy", 1'b0, busy);
    res_m = '{default: 10'h000};
    rx(16'hFFE8, 8'h00);
    rx(16'hFFE9, 8'h7E);
    for (int r = 0; r < 4; r++) rres(r);
    repeat (4) @(negedge clk);
    finish_test();
  end
endmodule : adri_register_interface_test
`default_nettype wire
